//--- shared/thermal_regs_pkg.sv
`default_nettype none
package thermal_regs_pkg;
	// register byte offsets
	localparam logic [7:0] ADDR_ALERT_MASK = 8'h75;
	localparam logic [7:0] ADDR_LOW_VOLT = 8'h76;
	localparam logic [7:0] ADDR_LOW_MIXED = 8'h77;
	localparam logic [7:0] ADDR_CONFIG = 8'h78;
	localparam logic [7:0] ADDR_TIMER = 8'h79;
	localparam logic [7:0] ADDR_LIMIT = 8'h7a;
	localparam logic [7:0] ADDR_CONTROL = 8'h90;
	localparam logic [7:0] ADDR_EVENTS = 8'h91;
	// values after reset
	localparam logic [7:0] RST_ALERT_MASK = 8'h00;
	localparam logic [7:0] RST_CONFIG = 8'h00;
	localparam logic [7:0] RST_LIMIT = 8'h00;
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_EVENTS = 8'h00;
	localparam logic [7:0] RST_LOW_BITS = 8'h00;
	// mask bit 1 is read-only, all others writable
	localparam logic [7:0] MASK_WR_BITS = 8'hfd;
	// event, mask and status layout
	localparam int EV_TWELVE = 0;
	localparam int EV_OVERTEMP = 1;
	localparam int EV_FIRST_FAN_FAULT_MASK = 2;
	localparam int EV_SHARED = 5;
	localparam int EV_DIODE1 = 6;
	// config_third fields
	localparam int CFG_ALERT = 0;
	localparam int CFG_OVERHEAT = 1;
	localparam int CFG_BOOST = 2;
	localparam int CFG_FAST = 3;
	localparam int CFG_CONT_LO = 4;
	// control register fields
	localparam int CTL_LOCK = 0;
	localparam int CTL_VID = 1;
	localparam int CTL_FUNC_LO = 2;
	typedef enum logic [1:0] {PIN_SPEED, PIN_OVERHEAT, PIN_GPIO, PIN_SPARE} shared_pin_function_t;
	// timing
	localparam real CLK_PERIOD_NS = 100.0;
	localparam real STEP_MS = 22.76;
	localparam real REPORT_FLOOR_MS = 45.52;
	localparam real SPEED_SLOW_MS = 1000.0;
	localparam real SPEED_FAST_MS = 250.0;
	localparam int STEP_CYCLES = int'(STEP_MS * 1.0e6 / CLK_PERIOD_NS);
	localparam int SPEED_SLOW_CYCLES = int'(SPEED_SLOW_MS * 1.0e6 / CLK_PERIOD_NS);
	localparam int SPEED_FAST_CYCLES = int'(SPEED_FAST_MS * 1.0e6 / CLK_PERIOD_NS);
	localparam logic [7:0] REPORT_FLOOR_STEPS = 8'(int'(REPORT_FLOOR_MS / STEP_MS));
	localparam logic [7:0] COUNT_MAX = 8'hff;
endpackage : thermal_regs_pkg
`default_nettype wire

//--- logic/freeze_tracker.sv
`timescale 1ns/1ps
`default_nettype none
module freeze_tracker
	import thermal_regs_pkg::*;
#(
	parameter int N = 4
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic low_read,
	input wire logic [N-1:0] high_read,
	output logic [N-1:0] hold_high,
	output logic frozen
);
	logic [N-1:0] pending;
	logic [N-1:0] next_pending;

	generate
		if (N < 1) begin : g_bad
			$error("freeze_tracker needs N of at least 1");
		end
	endgenerate

	// a new low-bits read re-arms every high byte, winning over a same-cycle high read
	always_comb begin
		next_pending = low_read ? {N{1'b1}} : (pending & ~high_read);
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pending <= '0;
		end else begin
			pending <= next_pending;
		end
	end

	assign hold_high = pending;
	assign frozen = |pending;

	chk_freeze_releases: assert property (@(posedge ref_clk) disable iff (rst)
		(frozen && !low_read && ((pending & ~high_read) == '0)) |=> !frozen)
		else $error("freeze did not release after every high byte was read");
endmodule : freeze_tracker
`default_nettype wire

//--- logic/overheat_timer.sv
`timescale 1ns/1ps
`default_nettype none
module overheat_timer
	import thermal_regs_pkg::*;
#(
	parameter int STEP_CYC = STEP_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic active,
	input wire logic clear,
	input wire logic [7:0] limit,
	output logic [7:0] status,
	output logic limit_event
);
	localparam int PW = (STEP_CYC > 1) ? $clog2(STEP_CYC) : 1;
	logic active_d, seen, next_seen, rise, tick;
	logic [7:0] count, next_count, bumped;
	logic [PW-1:0] pre, next_pre;

	generate
		if (STEP_CYC < 1) begin : g_bad
			$error("overheat_timer needs STEP_CYC of at least 1");
		end
	endgenerate

	assign rise = active & ~active_d;
	assign tick = active && (pre == PW'(STEP_CYC - 1));

	always_comb begin
		next_pre = (!active || tick) ? '0 : pre + PW'(1);
		bumped = (tick && count != COUNT_MAX) ? count + 8'h01 : count;
		// a step landing on the clearing read still counts
		next_count = clear ? (tick ? 8'h01 : 8'h00) : bumped;
		next_seen = rise | (seen & ~clear);
		// zero limit flags on the edge itself, otherwise on crossing the limit
		limit_event = (limit == 8'h00) ? rise : (count <= limit && bumped > limit);
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			active_d <= 1'b0;
			seen <= 1'b0;
			count <= 8'h00;
			pre <= '0;
		end else begin
			active_d <= active;
			seen <= next_seen;
			count <= next_count;
			pre <= next_pre;
		end
	end

	// below the floor only the assertion flag shows
	assign status = (count >= REPORT_FLOOR_STEPS) ? count : {7'h00, seen};

	sequence s_assert_edge;
		active && !active_d;
	endsequence

	chk_seen_on_edge: assert property (@(posedge ref_clk) disable iff (rst)
		s_assert_edge |=> status[0])
		else $error("assertion flag not set after overheat edge");
	chk_floor_zero: assert property (@(posedge ref_clk) disable iff (rst)
		(count < REPORT_FLOOR_STEPS) |-> (status[7:1] == 7'h00))
		else $error("duration bits shown before floor reached");
	chk_zero_limit: assert property (@(posedge ref_clk) disable iff (rst)
		(s_assert_edge and (limit == 8'h00)) |-> limit_event)
		else $error("zero limit did not flag on assertion");
endmodule : overheat_timer
`default_nettype wire

//--- logic/thermal_monitor_alert_mask_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module thermal_monitor_alert_mask_config_regs
	import thermal_regs_pkg::*;
#(
	parameter int STEP_CYC = STEP_CYCLES,
	parameter int SPEED_SLOW_CYC = SPEED_SLOW_CYCLES,
	parameter int SPEED_FAST_CYC = SPEED_FAST_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic we,
	input wire logic re,
	output logic [7:0] rdata,
	input wire logic [7:0] live_low_voltage,
	input wire logic [7:0] live_low_mixed,
	input wire logic [3:0] high_read_voltage,
	input wire logic [3:0] high_read_mixed,
	output logic [3:0] hold_high_voltage,
	output logic [3:0] hold_high_mixed,
	input wire logic overtemp_mask_src,
	input wire logic twelve_volt_ool,
	input wire logic voltage_id_bit_five_change,
	input wire logic [3:0] fan_fault,
	input wire logic [1:0] diode_fault,
	input wire logic overheat_pin_n,
	input wire logic shared_pin_n,
	input wire logic second_fan_drive_in,
	output logic alert_fan2_out,
	output logic alert_fan2_oe,
	output logic irq,
	output logic fans_full_boost,
	output logic speed_measure_strobe,
	output logic [3:0] continuous_speed_sense,
	output logic [1:0] shared_pin_function
);
	localparam int SPW = $clog2(SPEED_SLOW_CYC + 1);

	generate
		if (SPEED_FAST_CYC < 1 || SPEED_SLOW_CYC < SPEED_FAST_CYC) begin : g_bad
			$error("speed periods must satisfy 1 <= fast <= slow");
		end
	endgenerate

	function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
		return a == target;
	endfunction : hit

	// register state
	logic [7:0] alert_mask_second, next_alert_mask_second;
	logic [7:0] low_bits_voltage_group, next_low_bits_voltage_group;
	logic [7:0] low_bits_mixed_group, next_low_bits_mixed_group;
	logic [7:0] config_third, next_config_third;
	logic [7:0] assertion_limit, next_assertion_limit;
	logic [7:0] control, next_control;
	logic [7:0] event_status, next_event_status;
	logic [7:0] next_rdata;

	// pin and timing state
	logic alert_fan2_out_q, next_alert_fan2_out;
	logic alert_fan2_oe_q, next_alert_fan2_oe;
	logic next_fans_full_boost;
	logic [SPW-1:0] speed_cnt, next_speed_cnt;
	logic next_speed_measure_strobe;

	// derived signals
	shared_pin_function_t pin_func;
	logic lock, overheat_dedicated, overheat_shared, overheat_active;
	logic overheat_active_d, overtemp_rise;
	logic shared_event, limit_event, gpio_asserted;
	logic frozen_voltage, frozen_mixed;
	logic read_low_voltage, read_low_mixed, read_timer, read_events;
	logic [7:0] events_in, timer_status;
	logic [SPW-1:0] speed_last;

	assign lock = control[CTL_LOCK];
	assign pin_func = shared_pin_function_t'(control[CTL_FUNC_LO +: 2]);
	assign shared_pin_function = control[CTL_FUNC_LO +: 2];

	assign read_low_voltage = re && hit(addr, ADDR_LOW_VOLT);
	assign read_low_mixed = re && hit(addr, ADDR_LOW_MIXED);
	assign read_timer = re && hit(addr, ADDR_TIMER);
	assign read_events = re && hit(addr, ADDR_EVENTS);

	// overheat sources: the dedicated pin, plus the shared pin in its overheat role
	assign overheat_dedicated = ~overheat_pin_n;
	assign overheat_shared = (pin_func == PIN_OVERHEAT) && !shared_pin_n;
	assign overheat_active = config_third[CFG_OVERHEAT] && (overheat_dedicated || overheat_shared);
	assign overtemp_rise = overheat_active && !overheat_active_d;
	assign gpio_asserted = (pin_func == PIN_GPIO) && !shared_pin_n;

	freeze_tracker #(
		.N(4)
	) u_freeze_voltage (
		.ref_clk(ref_clk),
		.rst(rst),
		.low_read(read_low_voltage),
		.high_read(high_read_voltage),
		.hold_high(hold_high_voltage),
		.frozen(frozen_voltage)
	);

	freeze_tracker #(
		.N(4)
	) u_freeze_mixed (
		.ref_clk(ref_clk),
		.rst(rst),
		.low_read(read_low_mixed),
		.high_read(high_read_mixed),
		.hold_high(hold_high_mixed),
		.frozen(frozen_mixed)
	);

	overheat_timer #(
		.STEP_CYC(STEP_CYC)
	) u_timer (
		.ref_clk(ref_clk),
		.rst(rst),
		.active(overheat_active),
		.clear(read_timer),
		.limit(assertion_limit),
		.status(timer_status),
		.limit_event(limit_event)
	);

	// shared-pin event follows the pin's selected role
	always_comb begin
		case (pin_func)
			PIN_SPEED: shared_event = fan_fault[3];
			PIN_OVERHEAT: shared_event = limit_event;
			PIN_GPIO: shared_event = gpio_asserted;
			default: shared_event = 1'b0;
		endcase
	end

	// raw events in the mask layout
	always_comb begin
		events_in = 8'h00;
		events_in[EV_TWELVE] = control[CTL_VID] ? voltage_id_bit_five_change : twelve_volt_ool;
		events_in[EV_OVERTEMP] = overtemp_rise;
		events_in[EV_FIRST_FAN_FAULT_MASK +: 3] = fan_fault[2:0];
		events_in[EV_SHARED] = shared_event;
		events_in[EV_DIODE1 +: 2] = diode_fault;
	end

	// register writes, read side effects and low-bit capture
	always_comb begin
		next_alert_mask_second = alert_mask_second;
		next_config_third = config_third;
		next_assertion_limit = assertion_limit;
		next_control = control;
		// the read-only mask bit mirrors its source
		next_alert_mask_second[EV_OVERTEMP] = overtemp_mask_src;
		if (we && hit(addr, ADDR_ALERT_MASK)) begin
			next_alert_mask_second = (wdata & MASK_WR_BITS) | (alert_mask_second & ~MASK_WR_BITS);
			next_alert_mask_second[EV_OVERTEMP] = overtemp_mask_src;
		end else if (we && hit(addr, ADDR_CONFIG)) begin
			if (!lock) begin
				next_config_third = wdata;
			end
		end else if (we && hit(addr, ADDR_LIMIT)) begin
			next_assertion_limit = wdata;
		end else if (we && hit(addr, ADDR_CONTROL)) begin
			next_control = wdata;
			// lock stays set until reset
			next_control[CTL_LOCK] = wdata[CTL_LOCK] | lock;
		end
		// writes to low-bit, timer and event registers fall through untouched
		next_low_bits_voltage_group = frozen_voltage ? low_bits_voltage_group : live_low_voltage;
		next_low_bits_mixed_group = frozen_mixed ? low_bits_mixed_group : live_low_mixed;
		// a new event in the clearing read's cycle survives
		next_event_status = (read_events ? 8'h00 : event_status) | events_in;
	end

	// read data stands the cycle after the read strobe
	always_comb begin
		next_rdata = 8'h00;
		if (re) begin
			if (hit(addr, ADDR_ALERT_MASK)) begin
				next_rdata = alert_mask_second;
			end else if (hit(addr, ADDR_LOW_VOLT)) begin
				next_rdata = low_bits_voltage_group;
			end else if (hit(addr, ADDR_LOW_MIXED)) begin
				next_rdata = low_bits_mixed_group;
			end else if (hit(addr, ADDR_CONFIG)) begin
				next_rdata = config_third;
			end else if (hit(addr, ADDR_TIMER)) begin
				next_rdata = timer_status;
			end else if (hit(addr, ADDR_LIMIT)) begin
				next_rdata = assertion_limit;
			end else if (hit(addr, ADDR_CONTROL)) begin
				next_rdata = control;
			end else if (hit(addr, ADDR_EVENTS)) begin
				next_rdata = event_status;
			end
		end
	end

	// pins and measurement pacing
	always_comb begin
		if (config_third[CFG_ALERT]) begin
			// open-drain alert: pull low while an unmasked event is pending
			next_alert_fan2_out = 1'b0;
			next_alert_fan2_oe = |(next_event_status & ~next_alert_mask_second);
		end else begin
			next_alert_fan2_out = second_fan_drive_in;
			next_alert_fan2_oe = 1'b1;
		end
		next_fans_full_boost = config_third[CFG_BOOST] && overheat_active;
		speed_last = config_third[CFG_FAST] ? SPW'(SPEED_FAST_CYC - 1) : SPW'(SPEED_SLOW_CYC - 1);
		next_speed_measure_strobe = (speed_cnt >= speed_last);
		next_speed_cnt = next_speed_measure_strobe ? '0 : speed_cnt + SPW'(1);
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			alert_mask_second <= RST_ALERT_MASK;
			low_bits_voltage_group <= RST_LOW_BITS;
			low_bits_mixed_group <= RST_LOW_BITS;
			config_third <= RST_CONFIG;
			assertion_limit <= RST_LIMIT;
			control <= RST_CONTROL;
			event_status <= RST_EVENTS;
			rdata <= 8'h00;
			alert_fan2_out_q <= 1'b0;
			alert_fan2_oe_q <= 1'b0;
			fans_full_boost <= 1'b0;
			speed_cnt <= '0;
			speed_measure_strobe <= 1'b0;
			overheat_active_d <= 1'b0;
		end else begin
			alert_mask_second <= next_alert_mask_second;
			low_bits_voltage_group <= next_low_bits_voltage_group;
			low_bits_mixed_group <= next_low_bits_mixed_group;
			config_third <= next_config_third;
			assertion_limit <= next_assertion_limit;
			control <= next_control;
			event_status <= next_event_status;
			rdata <= next_rdata;
			alert_fan2_out_q <= next_alert_fan2_out;
			alert_fan2_oe_q <= next_alert_fan2_oe;
			fans_full_boost <= next_fans_full_boost;
			speed_cnt <= next_speed_cnt;
			speed_measure_strobe <= next_speed_measure_strobe;
			overheat_active_d <= overheat_active;
		end
	end

	assign alert_fan2_out = alert_fan2_out_q;
	assign alert_fan2_oe = alert_fan2_oe_q;
	assign irq = |(event_status & ~alert_mask_second);
	assign continuous_speed_sense = config_third[CFG_CONT_LO +: 4];

	// checks

	sequence s_low_voltage_read;
		re && addr == ADDR_LOW_VOLT;
	endsequence

	sequence s_all_high_open;
		hold_high_voltage == 4'hf;
	endsequence

	chk_lock_holds_config: assert property (@(posedge ref_clk) disable iff (rst)
		(lock && we && addr == ADDR_CONFIG) |=> config_third == $past(config_third))
		else $error("locked configuration register changed on write");

	chk_freeze_on_read: assert property (@(posedge ref_clk) disable iff (rst)
		s_low_voltage_read |=> s_all_high_open ##0 frozen_voltage)
		else $error("low-bits read did not freeze its high bytes");

	chk_frozen_low_stable: assert property (@(posedge ref_clk) disable iff (rst)
		frozen_voltage |=> $stable(low_bits_voltage_group))
		else $error("frozen low bits changed");

	chk_low_follows_live: assert property (@(posedge ref_clk) disable iff (rst)
		!frozen_voltage |=> low_bits_voltage_group == $past(live_low_voltage))
		else $error("unfrozen low bits did not follow measurement");

	chk_ro_write_ignored: assert property (@(posedge ref_clk) disable iff (rst)
		(we && addr == ADDR_LOW_MIXED && frozen_mixed) |=> $stable(low_bits_mixed_group))
		else $error("write changed a read-only low-bits register");

	chk_fan_masked: assert property (@(posedge ref_clk) disable iff (rst)
		((event_status & ~8'h1c) == 8'h00 && (alert_mask_second & 8'h1c) == 8'h1c) |-> !irq)
		else $error("masked fan fault raised the interrupt");

	chk_overtemp_gated: assert property (@(posedge ref_clk) disable iff (rst)
		(event_status == 8'h02) |-> (irq == !alert_mask_second[EV_OVERTEMP]))
		else $error("overtemperature alert not gated by its mask bit");

	chk_alert_pin_mode: assert property (@(posedge ref_clk) disable iff (rst)
		(config_third[CFG_ALERT] && irq && !read_events) |=> (alert_fan2_oe && !alert_fan2_out))
		else $error("alert pin not pulled low for pending alert");

	chk_fan2_pass: assert property (@(posedge ref_clk) disable iff (rst)
		!config_third[CFG_ALERT] |=> (alert_fan2_oe && alert_fan2_out == $past(second_fan_drive_in)))
		else $error("shared pin did not carry second fan drive");

	chk_boost_follows: assert property (@(posedge ref_clk) disable iff (rst)
		(config_third[CFG_BOOST] && overheat_active) |=> fans_full_boost)
		else $error("overheat with boost did not force full fan duty");

	chk_event_set_wins: assert property (@(posedge ref_clk) disable iff (rst)
		(read_events && events_in[EV_FIRST_FAN_FAULT_MASK]) |=> event_status[EV_FIRST_FAN_FAULT_MASK])
		else $error("event lost to a clearing read");

	chk_speed_pacing: assert property (@(posedge ref_clk) disable iff (rst)
		speed_measure_strobe |-> (speed_cnt == '0))
		else $error("measurement strobe out of step with its counter");
endmodule : thermal_monitor_alert_mask_config_regs
`default_nettype wire

//--- dv/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic ref_clk,
	output logic [7:0] addr,
	output logic [7:0] wdata,
	output logic we,
	output logic re,
	input wire logic [7:0] rdata
);
	initial begin
		addr = 8'h00;
		wdata = 8'h00;
		we = 1'b0;
		re = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge ref_clk);
		we <= 1'b0;
		// released lines carry a changed pattern, never the last value
		addr <= ~a;
		wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		re <= 1'b1;
		@(posedge ref_clk);
		re <= 1'b0;
		addr <= ~a;
		#1;
		d = rdata;
	endtask : rd
endmodule : host_model
`default_nettype wire

//--- dv/thermal_monitor_alert_mask_config_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module thermal_monitor_alert_mask_config_regs_test
	import thermal_regs_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr, wdata, rdata, v;
	logic we, re, ovt_src, v12, vid, ohp_n, shp_n, fdrv;
	logic [7:0] lv = 8'h1b;
	logic [7:0] lm = 8'h6c;
	logic [3:0] hrv = 4'h0;
	logic [3:0] hrm = 4'h0;
	logic [3:0] hhv, hhm, fan = 4'h0;
	logic [3:0] cont;
	logic [1:0] dio = 2'h0;
	logic [1:0] func;
	logic a_out, a_oe, irq, boost, strobe;
	int n_fail = 0;
	int total_checks = 0;
	int srcs[7] = '{0, 2, 3, 4, 5, 6, 7};
	int n;
	always #50 ref_clk = ~ref_clk;
	host_model host (.ref_clk(ref_clk), .addr(addr), .wdata(wdata), .we(we), .re(re),
		.rdata(rdata));
	thermal_monitor_alert_mask_config_regs #(.STEP_CYC(4), .SPEED_SLOW_CYC(16),
		.SPEED_FAST_CYC(4)) DUT (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
		.we(we), .re(re), .rdata(rdata), .live_low_voltage(lv), .live_low_mixed(lm),
		.high_read_voltage(hrv), .high_read_mixed(hrm), .hold_high_voltage(hhv),
		.hold_high_mixed(hhm), .overtemp_mask_src(ovt_src), .twelve_volt_ool(v12),
		.voltage_id_bit_five_change(vid), .fan_fault(fan), .diode_fault(dio),
		.overheat_pin_n(ohp_n), .shared_pin_n(shp_n), .second_fan_drive_in(fdrv),
		.alert_fan2_out(a_out), .alert_fan2_oe(a_oe), .irq(irq), .fans_full_boost(boost),
		.speed_measure_strobe(strobe), .continuous_speed_sense(cont),
		.shared_pin_function(func));
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rc(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host.rd(a, d);
		chk(d, exp);
	endtask : rc
	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask : cyc
	task automatic ev(input int i);
		@(posedge ref_clk);
		case (i)
			0: v12 <= 1'b1;
			6, 7: dio[i-6] <= 1'b1;
			default: fan[i-2] <= 1'b1;
		endcase
		@(posedge ref_clk);
		v12 <= 1'b0;
		fan <= 4'h0;
		dio <= 2'h0;
	endtask : ev
	// cycles from one measurement strobe to the next, bounded
	task automatic gap(output int k);
		int w;
		w = 0;
		while (strobe !== 1'b1 && w < 60) begin
			cyc(1);
			w++;
		end
		k = 0;
		do begin
			cyc(1);
			k++;
		end while (strobe !== 1'b1 && k < 60);
	endtask : gap
	initial begin
		#6000000;
		n_fail++;
		end_of_test();
	end
	initial begin
		{ovt_src, v12, vid, fdrv} = 4'h0;
		{ohp_n, shp_n} = 2'h3;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		rc(ADDR_ALERT_MASK, RST_ALERT_MASK);
		rc(ADDR_CONFIG, RST_CONFIG);
		rc(ADDR_TIMER, 8'h00);
		@(posedge ref_clk) fdrv <= 1'b1;
		cyc(3);
		chk(8'(a_oe), 8'h01);
		chk(8'(a_out), 8'h01);
		host.wr(ADDR_ALERT_MASK, 8'hff);
		rc(ADDR_ALERT_MASK, 8'hfd);
		@(posedge ref_clk) ovt_src <= 1'b1;
		rc(ADDR_ALERT_MASK, 8'hff);
		host.wr(ADDR_CONFIG, 8'h01);
		foreach (srcs[k]) begin
			host.wr(ADDR_ALERT_MASK, ~(8'h01 << srcs[k]));
			ev(srcs[k]);
			cyc(2);
			chk(8'(irq), 8'h01);
			chk({a_oe, a_out}, 8'h02);
			rc(ADDR_EVENTS, 8'h01 << srcs[k]);
			cyc(1);
			chk(8'(irq), 8'h00);
			host.wr(ADDR_ALERT_MASK, 8'hff);
			ev(srcs[k]);
			cyc(2);
			chk(8'(irq), 8'h00);
			rc(ADDR_EVENTS, 8'h01 << srcs[k]);
		end
		host.wr(ADDR_CONTROL, 8'h02);
		host.wr(ADDR_ALERT_MASK, 8'hfe);
		@(posedge ref_clk) vid <= 1'b1;
		@(posedge ref_clk) vid <= 1'b0;
		cyc(2);
		chk(8'(irq), 8'h01);
		rc(ADDR_EVENTS, 8'h01);
		host.wr(ADDR_CONTROL, 8'h00);
		@(posedge ref_clk) ovt_src <= 1'b0;
		host.wr(ADDR_ALERT_MASK, 8'h00);
		host.wr(ADDR_CONFIG, 8'h07);
		@(posedge ref_clk) ohp_n <= 1'b0;
		cyc(2);
		rc(ADDR_TIMER, 8'h01);
		chk(8'(irq), 8'h01);
		chk(8'(boost), 8'h01);
		rc(ADDR_EVENTS, 8'h02);
		cyc(40);
		host.rd(ADDR_TIMER, v);
		chk(8'(v >= 8'h08 && v <= 8'h10), 8'h01);
		@(posedge ref_clk) ohp_n <= 1'b1;
		cyc(2);
		chk(8'(boost), 8'h00);
		host.rd(ADDR_TIMER, v);
		host.wr(ADDR_TIMER, 8'hff);
		rc(ADDR_TIMER, 8'h00);
		host.wr(ADDR_CONTROL, 8'h04);
		// let the write edge settle before looking at the register output
		cyc(0);
		chk(8'(func), 8'h01);
		@(posedge ref_clk) shp_n <= 1'b0;
		cyc(2);
		rc(ADDR_EVENTS, 8'h22);
		@(posedge ref_clk) shp_n <= 1'b1;
		host.rd(ADDR_TIMER, v);
		host.wr(ADDR_LIMIT, 8'h02);
		@(posedge ref_clk) shp_n <= 1'b0;
		cyc(2);
		rc(ADDR_EVENTS, 8'h02);
		cyc(16);
		rc(ADDR_EVENTS, 8'h20);
		@(posedge ref_clk) shp_n <= 1'b1;
		rc(ADDR_LOW_VOLT, 8'h1b);
		@(posedge ref_clk) lv <= 8'he4;
		cyc(3);
		chk(8'(hhv), 8'h0f);
		rc(ADDR_LOW_VOLT, 8'h1b);
		host.wr(ADDR_LOW_VOLT, 8'h55);
		@(posedge ref_clk) hrv <= 4'hf;
		@(posedge ref_clk) hrv <= 4'h0;
		cyc(3);
		rc(ADDR_LOW_VOLT, 8'he4);
		rc(ADDR_LOW_MIXED, 8'h6c);
		@(posedge ref_clk) hrm <= 4'hf;
		@(posedge ref_clk) hrm <= 4'h0;
		cyc(2);
		chk(8'(hhm), 8'h00);
		gap(n);
		chk(8'(n), 8'h10);
		host.wr(ADDR_CONFIG, 8'ha8);
		cyc(0);
		chk(8'(cont), 8'h0a);
		cyc(20);
		gap(n);
		chk(8'(n), 8'h04);
		host.wr(ADDR_CONTROL, 8'h05);
		host.wr(ADDR_CONFIG, 8'h00);
		rc(ADDR_CONFIG, 8'ha8);
		host.wr(ADDR_CONTROL, 8'h04);
		rc(ADDR_CONTROL, 8'h05);
		host.wr(8'h80, 8'hff);
		rc(8'h80, 8'h00);
		end_of_test();
	end
endmodule : thermal_monitor_alert_mask_config_regs_test
`default_nettype wire
